// *** verilog/msv_map.vh ***
// register map, field positions, reset values and timing counts of the motor supervisor
`ifndef MSV_MAP_VH
`define MSV_MAP_VH
`define MSV_CLK_NS 50
`define MSV_TICK_NS 1000000
`define MSV_A_CTRL 8'h00
`define MSV_A_POTSC 8'h04
`define MSV_A_SPDSC 8'h08
`define MSV_A_SPDG 8'h0C
`define MSV_A_CURG 8'h10
`define MSV_A_CURD 8'h14
`define MSV_A_STALL 8'h18
`define MSV_A_OVSPD 8'h1C
`define MSV_A_OVV 8'h20
`define MSV_A_OVC 8'h24
`define MSV_A_TOL 8'h28
`define MSV_A_ROT 8'h2C
`define MSV_A_STAT 8'h30
`define MSV_A_OFFS 8'h34
`define MSV_C_RUN 0
`define MSV_C_CLR 1
`define MSV_C_MODE_LO 2
`define MSV_C_MODE_HI 3
`define MSV_C_AUTO 4
`define MSV_F_OC 0
`define MSV_F_OV 1
`define MSV_F_LOST 2
`define MSV_F_STALL 3
`define MSV_F_START 4
`define MSV_F_EXT 5
`define MSV_MODE_SPD 2'h0
`define MSV_MODE_CAS 2'h1
`define MSV_MODE_OPEN 2'h2
`define MSV_MODE_CUR 2'h3
`define MSV_R_CTRL 32'h00000018
`define MSV_R_POTSC 32'h01000100
`define MSV_R_SPDSC 16'h0100
`define MSV_R_SPDG 32'h00100100
`define MSV_R_CURG 32'h00100100
`define MSV_R_CURD 16'h0000
`define MSV_R_STALL 16'h01F4
`define MSV_R_OVSPD 16'h0CE4
`define MSV_R_OVV 16'h0FA0
`define MSV_R_OVC 16'h0064
`define MSV_R_TOL 7'h32
`define MSV_R_ROT 16'h03E8
`define MSV_OV_MARGIN 16'h0032
`define MSV_TOL_OFF 7'h63
`endif

// *** verilog/msv_pid.v ***
// proportional-integral-derivative regulator with unsigned saturated output
`timescale 1ns/1ps
`include "msv_map.vh"
module msv_pid #(
  parameter W = 16
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire en,
  input wire tick,
  input wire [W-1:0] kp,
  input wire [W-1:0] ki,
  input wire [W-1:0] kd,
  input wire [W-1:0] sp,
  input wire [W-1:0] fb,
  output reg [W-1:0] out
);
  wire signed [W:0] err = $signed({1'b0, sp}) - $signed({1'b0, fb});
  reg signed [W:0] err_prev;
  reg signed [W+7:0] integ;
  wire signed [W+8:0] isum = integ + err;
  wire signed [W+8:0] ilim = {{2{1'b0}}, {(W+6){1'b1}}, 1'b1};
  wire signed [W+7:0] inext;
  wire signed [2*W+16:0] acc;
  wire signed [2*W+16:0] scaled;
  // clamp bounds the integrator to plus or minus ilim at every tick, whether or not the output is saturated
  assign inext = (isum > ilim) ? ilim[W+7:0] :
                 (isum < -ilim) ? -ilim[W+7:0] : isum[W+7:0];
  assign acc = $signed({1'b0, kp}) * err + $signed({1'b0, ki}) * integ
             + $signed({1'b0, kd}) * (err - err_prev);
  assign scaled = acc >>> 12;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out <= {W{1'b0}};
      err_prev <= {(W+1){1'b0}};
      integ <= {(W+8){1'b0}};
    end
    else if (ce)
    begin
      if (!en)
      begin
        out <= {W{1'b0}};
        err_prev <= {(W+1){1'b0}};
        integ <= {(W+8){1'b0}};
      end
      else if (tick)
      begin
        integ <= inext;
        err_prev <= err;
        if (scaled < 0)
          out <= {W{1'b0}};
        else if (scaled > $signed({1'b0, {W{1'b1}}}))
          out <= {W{1'b1}};
        else
          out <= scaled[W-1:0];
      end
    end
  end
endmodule

// *** verilog/msv_top.v ***
// sensorless motor supervisor: loop selection, fault supervision, start-up and APB registers
// Function
// - mode 3 runs the current loop alone, setpoint from potentiometer; speed loop off
// - potentiometer times current-scaling setting forms the current setpoint in mode 3
// - mode 0 speed loop is PI with two separately configurable gains
// - current loop is PID with three configurable gains whenever it runs
// - mode 1 uses the speed gain set and current gain set together
// - stall flagged only after configurable delay without zero crossings; crossings rearm it
// - speed above configurable ceiling, default 3300 rpm, raises over-current fault
// - bus voltage at ceiling in 0.1 V units switches brake chopper on
// - bus current above ceiling in 0.1 A units raises over-current fault
// - crossing interval above previous interval by tolerance percent enters lost tracking
// - tolerance of 99 percent disables the interval check
// - start waits timeout for turning motor; acquisition runs, else lock and ramp
// - zero offset of bus current taken once after reset
// - distinct indications for over-current, over-voltage, lost, stall, start fail, trip
// - auto re-acquire enable decides whether acquisition follows lost tracking
// - mode 1 speed loop output feeds current setpoint; current output sets duty
// - mode 2 runs no loop; scaled potentiometer sets duty; it is the default
// - mode 0 speed loop output sets duty, setpoint from scaled potentiometer
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "msv_map.vh"
module msv_top #(
  parameter TICK_CYCLES = `MSV_TICK_NS / `MSV_CLK_NS,
  parameter PER_W = 24
) (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [11:0] pot,
  input wire [15:0] speed_rpm,
  input wire [15:0] bus_volt,
  input wire [15:0] bus_cur_raw,
  input wire zero_cross,
  input wire acq_ok,
  input wire ramp_done,
  input wire external_trip,
  output reg drive_en,
  output reg [15:0] duty,
  output reg brake_on,
  output reg ramp_req,
  output wire oc_fault,
  output wire ov_fault,
  output wire lost_fault,
  output wire stall_fault,
  output wire startup_fail_fault,
  output wire external_trip_fault
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_WAIT = 5'h02;
  localparam [4:0] ST_RAMP = 5'h04;
  localparam [4:0] ST_RUN = 5'h08;
  localparam [4:0] ST_FAULT = 5'h10;

  reg [31:0] ctrl_reg;
  reg [31:0] potsc_reg;
  reg [15:0] spdsc_reg;
  reg [31:0] spdg_reg;
  reg [31:0] curg_reg;
  reg [15:0] curd_reg;
  reg [15:0] stall_reg;
  reg [15:0] ovspd_reg;
  reg [15:0] ovv_reg;
  reg [15:0] ovc_reg;
  reg [6:0] tol_reg;
  reg [15:0] rot_reg;
  reg [15:0] offs_reg;
  reg offs_valid_reg;
  reg [5:0] fault_reg;
  reg [5:0] fault_next;
  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg [31:0] tick_cnt_reg;
  reg [15:0] tmo_cnt_reg;
  reg [15:0] stall_cnt_reg;
  reg [PER_W-1:0] per_cnt_reg;
  reg [PER_W-1:0] per_prev_reg;
  reg per_valid_reg;
  reg [31:0] rdata;
  reg rd_ok;

  wire wr = psel & penable & pwrite;
  wire tick = (tick_cnt_reg == TICK_CYCLES - 1);
  wire [1:0] mode = ctrl_reg[`MSV_C_MODE_HI:`MSV_C_MODE_LO];
  wire clr = ce & wr & (paddr == `MSV_A_CTRL) & pwdata[`MSV_C_CLR];
  wire running = state_reg[3];

  // bus current with its start-up offset removed, floored at zero
  wire [15:0] cur_meas = (bus_cur_raw > offs_reg) ? bus_cur_raw - offs_reg : 16'h0000;

  // scaled potentiometer demands, 8 fractional bits in each scale
  wire [27:0] pot_cur_p = pot * potsc_reg[15:0];
  wire [27:0] pot_duty_p = pot * potsc_reg[31:16];
  wire [27:0] pot_spd_p = pot * spdsc_reg;
  wire [15:0] pot_cur = pot_cur_p[23:8];
  wire [15:0] pot_duty = pot_duty_p[23:8];
  wire [15:0] pot_spd = pot_spd_p[23:8];

  wire spd_en = running & ((mode == `MSV_MODE_SPD) | (mode == `MSV_MODE_CAS));
  wire cur_en = running & ((mode == `MSV_MODE_CAS) | (mode == `MSV_MODE_CUR));
  wire [15:0] spd_out;
  wire [15:0] cur_out;
  wire [15:0] cur_sp = (mode == `MSV_MODE_CAS) ? spd_out : pot_cur;

  // speed loop has no derivative term
  msv_pid #(
    .W(16)
  ) u_spd (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .en(spd_en),
    .tick(tick),
    .kp(spdg_reg[15:0]),
    .ki(spdg_reg[31:16]),
    .kd(16'h0000),
    .sp(pot_spd),
    .fb(speed_rpm),
    .out(spd_out)
  );

  msv_pid #(
    .W(16)
  ) u_cur (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .en(cur_en),
    .tick(tick),
    .kp(curg_reg[15:0]),
    .ki(curg_reg[31:16]),
    .kd(curd_reg),
    .sp(cur_sp),
    .fb(cur_meas),
    .out(cur_out)
  );

  // interval check: products stay inside 32 bits for PER_W up to 24
  wire [31:0] per_scaled = per_cnt_reg * 8'd100;
  wire [31:0] prev_scaled = per_prev_reg * (8'd100 + {1'b0, tol_reg});
  wire tol_on = (tol_reg < `MSV_TOL_OFF);
  wire per_bad = zero_cross & per_valid_reg & tol_on & (per_scaled > prev_scaled);

  wire ev_oc = cur_meas > ovc_reg;
  wire [16:0] ov_trip = {1'b0, ovv_reg} + {1'b0, `MSV_OV_MARGIN};
  wire ev_ov = {1'b0, bus_volt} >= ov_trip;
  wire ev_spd = running & (speed_rpm > ovspd_reg);
  wire ev_stall = running & tick & (stall_cnt_reg >= stall_reg);
  wire ev_start = state_reg[2] & ramp_done & ~acq_ok;
  wire ev_lost = running & per_bad;
  wire [5:0] fault_ev;
  // over-speed shares the over-current indication as a drive overload
  assign fault_ev[`MSV_F_OC] = ev_oc | ev_spd;
  assign fault_ev[`MSV_F_OV] = ev_ov;
  assign fault_ev[`MSV_F_LOST] = ev_lost;
  assign fault_ev[`MSV_F_STALL] = ev_stall;
  assign fault_ev[`MSV_F_START] = ev_start;
  assign fault_ev[`MSV_F_EXT] = external_trip;
  wire [5:0] trip_mask = ctrl_reg[`MSV_C_AUTO] ? 6'h3B : 6'h3F;
  wire trip = |(fault_ev & trip_mask);

  assign oc_fault = fault_reg[`MSV_F_OC];
  assign ov_fault = fault_reg[`MSV_F_OV];
  assign lost_fault = fault_reg[`MSV_F_LOST];
  assign stall_fault = fault_reg[`MSV_F_STALL];
  assign startup_fail_fault = fault_reg[`MSV_F_START];
  assign external_trip_fault = fault_reg[`MSV_F_EXT];

  always @*
  begin
    // a new event in the clearing cycle survives
    fault_next = (clr ? 6'h00 : fault_reg) | fault_ev;
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (ctrl_reg[`MSV_C_RUN] & ~trip)
          state_next = ST_WAIT;
      ST_WAIT:
        if (trip)
          state_next = ST_FAULT;
        else if (acq_ok)
          state_next = ST_RUN;
        else if (tick & (tmo_cnt_reg >= rot_reg))
          state_next = ST_RAMP;
      ST_RAMP:
        // a trip in the acquisition cycle must not leave the drive enabled
        if (trip)
          state_next = ST_FAULT;
        else if (acq_ok)
          state_next = ST_RUN;
      ST_RUN:
        if (trip)
          state_next = ST_FAULT;
        else if (ev_lost)
          state_next = ST_WAIT;
        else if (~ctrl_reg[`MSV_C_RUN])
          state_next = ST_IDLE;
      ST_FAULT:
        if (clr)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= ST_IDLE;
      fault_reg <= 6'h00;
      tick_cnt_reg <= 32'h00000000;
      tmo_cnt_reg <= 16'h0000;
      stall_cnt_reg <= 16'h0000;
      per_cnt_reg <= {PER_W{1'b0}};
      per_prev_reg <= {PER_W{1'b0}};
      per_valid_reg <= 1'b0;
      offs_reg <= 16'h0000;
      offs_valid_reg <= 1'b0;
      drive_en <= 1'b0;
      duty <= 16'h0000;
      brake_on <= 1'b0;
      ramp_req <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      fault_reg <= fault_next;
      tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
      // only a reset re-arms the offset capture
      if (!offs_valid_reg)
      begin
        offs_reg <= bus_cur_raw;
        offs_valid_reg <= 1'b1;
      end
      if (state_next != state_reg)
        tmo_cnt_reg <= 16'h0000;
      else if (tick & (tmo_cnt_reg != 16'hFFFF))
        tmo_cnt_reg <= tmo_cnt_reg + 16'h0001;
      if (zero_cross | ~running)
        stall_cnt_reg <= 16'h0000;
      else if (tick & (stall_cnt_reg != 16'hFFFF))
        stall_cnt_reg <= stall_cnt_reg + 16'h0001;
      if (~running)
      begin
        per_cnt_reg <= {PER_W{1'b0}};
        per_valid_reg <= 1'b0;
      end
      else if (zero_cross)
      begin
        per_prev_reg <= per_cnt_reg;
        per_cnt_reg <= {PER_W{1'b0}};
        per_valid_reg <= 1'b1;
      end
      else if (~&per_cnt_reg)
        per_cnt_reg <= per_cnt_reg + {{(PER_W-1){1'b0}}, 1'b1};
      drive_en <= (state_next == ST_RAMP) | (state_next == ST_RUN);
      ramp_req <= (state_next == ST_RAMP);
      brake_on <= (bus_volt >= ovv_reg);
      if (state_next != ST_RUN)
        duty <= 16'h0000;
      else if (mode == `MSV_MODE_OPEN)
        duty <= pot_duty;
      else if (mode == `MSV_MODE_SPD)
        duty <= spd_out;
      else
        duty <= cur_out;
    end
  end

  // register writes; the clear bit is a strobe and is not stored
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `MSV_R_CTRL;
      potsc_reg <= `MSV_R_POTSC;
      spdsc_reg <= `MSV_R_SPDSC;
      spdg_reg <= `MSV_R_SPDG;
      curg_reg <= `MSV_R_CURG;
      curd_reg <= `MSV_R_CURD;
      stall_reg <= `MSV_R_STALL;
      ovspd_reg <= `MSV_R_OVSPD;
      ovv_reg <= `MSV_R_OVV;
      ovc_reg <= `MSV_R_OVC;
      tol_reg <= `MSV_R_TOL;
      rot_reg <= `MSV_R_ROT;
    end
    else if (ce & wr)
    begin
      if (paddr == `MSV_A_CTRL)
        ctrl_reg <= {27'h0000000, pwdata[4:2], 1'b0, pwdata[0]};
      else if (paddr == `MSV_A_POTSC)
        potsc_reg <= pwdata;
      else if (paddr == `MSV_A_SPDSC)
        spdsc_reg <= pwdata[15:0];
      else if (paddr == `MSV_A_SPDG)
        spdg_reg <= pwdata;
      else if (paddr == `MSV_A_CURG)
        curg_reg <= pwdata;
      else if (paddr == `MSV_A_CURD)
        curd_reg <= pwdata[15:0];
      else if (paddr == `MSV_A_STALL)
        stall_reg <= pwdata[15:0];
      else if (paddr == `MSV_A_OVSPD)
        ovspd_reg <= pwdata[15:0];
      else if (paddr == `MSV_A_OVV)
        ovv_reg <= pwdata[15:0];
      else if (paddr == `MSV_A_OVC)
        ovc_reg <= pwdata[15:0];
      else if (paddr == `MSV_A_TOL)
        tol_reg <= pwdata[6:0];
      else if (paddr == `MSV_A_ROT)
        rot_reg <= pwdata[15:0];
    end
  end

  always @*
  begin
    rd_ok = 1'b1;
    rdata = 32'h00000000;
    if (paddr == `MSV_A_CTRL)
      rdata = ctrl_reg;
    else if (paddr == `MSV_A_POTSC)
      rdata = potsc_reg;
    else if (paddr == `MSV_A_SPDSC)
      rdata = {16'h0000, spdsc_reg};
    else if (paddr == `MSV_A_SPDG)
      rdata = spdg_reg;
    else if (paddr == `MSV_A_CURG)
      rdata = curg_reg;
    else if (paddr == `MSV_A_CURD)
      rdata = {16'h0000, curd_reg};
    else if (paddr == `MSV_A_STALL)
      rdata = {16'h0000, stall_reg};
    else if (paddr == `MSV_A_OVSPD)
      rdata = {16'h0000, ovspd_reg};
    else if (paddr == `MSV_A_OVV)
      rdata = {16'h0000, ovv_reg};
    else if (paddr == `MSV_A_OVC)
      rdata = {16'h0000, ovc_reg};
    else if (paddr == `MSV_A_TOL)
      rdata = {25'h0000000, tol_reg};
    else if (paddr == `MSV_A_ROT)
      rdata = {16'h0000, rot_reg};
    else if (paddr == `MSV_A_STAT)
      rdata = {16'h0000, brake_on, drive_en, 1'b0, state_reg, 2'h0, fault_reg};
    else if (paddr == `MSV_A_OFFS)
      rdata = {15'h0000, offs_valid_reg, offs_reg};
    else
      rd_ok = 1'b0;
  end

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~rd_ok;
  assign prdata = (psel & ~pwrite) ? rdata : 32'h00000000;
endmodule

// *** tb/msv_monitor.sv ***
// port checker for the motor supervisor, bound onto its top module
`timescale 1ns/1ps
module msv_monitor (
  input wire pclk,
  input wire presetn,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [15:0] bus_volt,
  input wire acq_ok,
  input wire ramp_done,
  input wire external_trip,
  input wire drive_en,
  input wire [15:0] duty,
  input wire brake_on,
  input wire ramp_req,
  input wire oc_fault,
  input wire ov_fault,
  input wire lost_fault,
  input wire stall_fault,
  input wire startup_fail_fault,
  input wire external_trip_fault
);
  wire acc = psel && penable && ce;
  wire clr = acc && pwrite && paddr == 8'h00 && pwdata[1];
  wire unmapped = paddr > 8'h34 || paddr[1:0] != 2'h0;
  wire [5:0] flt = {external_trip_fault, startup_fail_fault, stall_fault, lost_fault,
    ov_fault, oc_fault};
  // shadow of the voltage ceiling so the brake threshold can be judged from outside
  reg [15:0] ovv_reg;
  wire at_ceil = bus_volt >= ovv_reg;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      ovv_reg <= 16'h0FA0;
    else if (acc && pwrite && paddr == 8'h20)
      ovv_reg <= pwdata[15:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ramp_gave_up;
    ramp_req && ramp_done && !acq_ok;
  endsequence
  sequence trip_seen;
    ce && external_trip;
  endsequence
  apb_answer_a: assert property (pready && pslverr == (psel && penable && unmapped))
    else $error("apb answer wrong");
  read_idle_a: assert property ((!psel || pwrite || unmapped) |-> prdata == 32'h00000000)
    else $error("read data not zero");
  trip_latch_a: assert property (trip_seen |=> external_trip_fault)
    else $error("trip not latched");
  fault_hold_a: assert property (flt != 6'h00 && !clr |=> (flt & $past(flt)) == $past(flt))
    else $error("fault dropped");
  drive_cut_a: assert property ((flt & ~$past(flt)) != 6'h00 |-> !drive_en)
    else $error("drive on with new fault");
  duty_off_a: assert property (!drive_en |-> duty == 16'h0000)
    else $error("duty without drive");
  brake_level_a: assert property (ce |=> brake_on == $past(at_ceil))
    else $error("brake wrong");
  volt_fault_a: assert property (ce && {1'b0, bus_volt} >= ovv_reg + 17'h00032 |=> ov_fault)
    else $error("over voltage missed");
  start_fail_a: assert property (ce ##0 ramp_gave_up |=> startup_fail_fault)
    else $error("start failure missed");
endmodule
bind msv_top msv_monitor u_mon (.*);

// *** tb/msv_inverter.sv ***
// behavioural power stage and motor: crossings, acquisition and ramp replies
`timescale 1ns/1ps
module msv_inverter (
  input wire pclk,
  input wire drive_en,
  input wire ramp_req,
  input wire spinning,
  input wire ramp_ok,
  input wire [7:0] period,
  output reg zero_cross = 1'b0,
  output reg acq_ok = 1'b0,
  output reg ramp_done = 1'b0
);
  reg [7:0] cnt_reg = 8'h00;
  reg [7:0] ramp_reg = 8'h00;
  // no crossings at all while undriven, so a stopped motor really looks stopped
  always @(posedge pclk)
  begin
    cnt_reg <= (drive_en && cnt_reg + 8'h01 < period) ? cnt_reg + 8'h01 : 8'h00;
    zero_cross <= drive_en && period != 8'h00 && cnt_reg + 8'h01 == period;
    ramp_reg <= ramp_req ? ramp_reg + 8'h01 : 8'h00;
    ramp_done <= ramp_req && ramp_reg == 8'h28;
    acq_ok <= spinning || (ramp_ok && ramp_req && ramp_reg == 8'h14);
  end
endmodule

// *** tb/msv_top_tb.sv ***
// self-checking bench for the motor supervisor
`timescale 1ns/1ps
`include "msv_map.vh"
module msv_top_tb;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h00000000;
  reg [11:0] pot = 12'h800;
  reg [15:0] speed_rpm = 16'h0000, bus_volt = 16'h0BB8, bus_cur_raw = 16'h0010;
  reg external_trip = 1'b0, spinning = 1'b1, ramp_ok = 1'b1, ce = 1'b1;
  reg [7:0] period = 8'h14;
  wire [31:0] prdata;
  wire [15:0] duty;
  wire pready, pslverr, zero_cross, acq_ok, ramp_done, drive_en, brake_on, ramp_req;
  wire oc_fault, ov_fault, lost_fault, stall_fault, startup_fail_fault, external_trip_fault;
  wire [5:0] flt = {external_trip_fault, startup_fail_fault, stall_fault, lost_fault,
    ov_fault, oc_fault};
  wire [7:0] obs = {ramp_req, drive_en, flt};
  localparam [14:0] FB = {3'h3, 3'h5, 3'h1, 3'h0, 3'h0};
  integer bad_count = 0, comparisons = 0, seed = 11260, i;
  reg [31:0] rd;
  reg err;
  reg [3:0] f;
  msv_top #(.TICK_CYCLES(10)) dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pot, .speed_rpm, .bus_volt, .bus_cur_raw,
    .zero_cross, .acq_ok, .ramp_done, .external_trip, .drive_en, .duty, .brake_on,
    .ramp_req, .oc_fault, .ov_fault, .lost_fault, .stall_fault, .startup_fail_fault,
    .external_trip_fault);
  msv_inverter u_inv (.pclk, .drive_en, .ramp_req, .spinning, .ramp_ok, .period,
    .zero_cross, .acq_ok, .ramp_done);
  initial
    forever #25 pclk = ~pclk;
  task end_of_test;
  begin
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    integer n;
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  endtask
  task wait_for(input [2:0] s, input v);
    integer n;
  begin
    n = 0;
    while (obs[s] !== v && n < 400)
    begin
      n = n + 1;
      @(posedge pclk);
    end
    if (n == 400)
    begin
      bad_count = bad_count + 1;
      end_of_test;
    end
  end
  endtask
  task start(input [1:0] m, input au);
  begin
    apb(1'b1, `MSV_A_CTRL, {27'h0, au, m, 2'h1});
    wait_for(3'h6, 1'b1);
  end
  endtask
  task stop;
  begin
    apb(1'b1, `MSV_A_CTRL, 32'h00000002);
    // the run bit is seen one edge after the write, and the duty goes to zero at that same edge
    repeat (2) @(posedge pclk);
  end
  endtask
  task nominal;
  begin
    bus_cur_raw <= 16'h0010;
    speed_rpm <= 16'h0000;
    bus_volt <= 16'h0BB8;
    external_trip <= 1'b0;
    period <= 8'h14;
  end
  endtask
  function [31:0] rst_val(input [3:0] k);
    case (k)
      4'h0: rst_val = `MSV_R_CTRL;
      4'h1: rst_val = `MSV_R_POTSC;
      4'h2: rst_val = `MSV_R_SPDSC;
      4'h3: rst_val = `MSV_R_SPDG;
      4'h4: rst_val = `MSV_R_CURG;
      4'h5: rst_val = `MSV_R_CURD;
      4'h6: rst_val = `MSV_R_STALL;
      4'h7: rst_val = 32'h00000CE4;
      4'h8: rst_val = `MSV_R_OVV;
      4'h9: rst_val = `MSV_R_OVC;
      4'hA: rst_val = `MSV_R_TOL;
      default: rst_val = `MSV_R_ROT;
    endcase
  endfunction
  function duty_on(input [1:0] m, input [3:0] g);
    case (m)
      2'h0: duty_on = g[0];
      2'h1: duty_on = g[0] & g[1];
      2'h2: duty_on = g[3];
      default: duty_on = g[1] & g[2];
    endcase
  endfunction
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 12; i = i + 1)
    begin
      apb(1'b0, i * 4, 32'h0);
      chk(rd, rst_val(i));
    end
    apb(1'b0, 8'h38, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, `MSV_A_OFFS, 32'h0);
    bus_cur_raw <= 16'h0020;
    apb(1'b0, `MSV_A_OFFS, 32'h0);
    chk({err, rd[30:0]}, 32'h00010010);
    nominal;
    apb(1'b1, `MSV_A_STALL, 32'h0000000A);
    apb(1'b1, `MSV_A_ROT, 32'h00000003);
    spinning <= 1'b0;
    ramp_ok <= 1'b0;
    apb(1'b1, `MSV_A_CTRL, 32'h00000019);
    repeat (15) @(posedge pclk);
    chk(ramp_req, 1'b0);
    wait_for(3'h7, 1'b1);
    wait_for(3'h4, 1'b1);
    @(posedge pclk);
    chk({drive_en, flt}, 7'h10);
    stop;
    chk(flt, 6'h00);
    ramp_ok <= 1'b1;
    start(2'h2, 1'b1);
    wait_for(3'h7, 1'b0);
    chk({drive_en, flt}, 7'h40);
    stop;
    spinning <= 1'b1;
    for (i = 0; i < 12; i = i + 1)
    begin
      f = $random(seed);
      pot <= 12'h800 | $random(seed);
      apb(1'b1, `MSV_A_SPDG, f[0] ? 32'h00100100 : 32'h0);
      apb(1'b1, `MSV_A_CURG, f[1] ? 32'h00100100 : 32'h0);
      apb(1'b1, `MSV_A_POTSC, {f[3] ? 16'h0100 : 16'h0, f[2] ? 16'h0100 : 16'h0});
      start(i[1:0], 1'b1);
      repeat (200) @(posedge pclk);
      chk(|duty, duty_on(i[1:0], f));
      stop;
      chk({flt, duty}, 32'h0);
    end
    start(2'h2, 1'b1);
    bus_cur_raw <= 16'h0074;
    speed_rpm <= 16'h0CE4;
    bus_volt <= 16'h0F9F;
    repeat (3) @(posedge pclk);
    chk({brake_on, flt}, 7'h00);
    bus_volt <= 16'h0FD1;
    repeat (3) @(posedge pclk);
    chk({brake_on, flt}, 7'h40);
    // clock enable low must freeze the fault latch and the drive
    ce <= 1'b0;
    external_trip <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({drive_en, flt}, 7'h40);
    ce <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({drive_en, flt}, 7'h20);
    nominal;
    stop;
    for (i = 0; i < 5; i = i + 1)
    begin
      nominal;
      start(2'h2, 1'b1);
      case (i)
        0: bus_cur_raw <= 16'h0075;
        1: speed_rpm <= 16'h0CE5;
        2: bus_volt <= 16'h0FD2;
        3: external_trip <= 1'b1;
        default: period <= 8'h00;
      endcase
      wait_for(FB[i * 3 +: 3], 1'b1);
      @(posedge pclk);
      chk({drive_en, flt}, 6'h01 << FB[i * 3 +: 3]);
      nominal;
      stop;
    end
    start(2'h2, 1'b1);
    period <= 8'h1E;
    repeat (100) @(posedge pclk);
    chk(flt, 6'h00);
    period <= 8'h2E;
    wait_for(3'h2, 1'b1);
    repeat (60) @(posedge pclk);
    chk({drive_en, flt}, 7'h44);
    nominal;
    stop;
    start(2'h2, 1'b0);
    period <= 8'h1E;
    repeat (100) @(posedge pclk);
    period <= 8'h2E;
    wait_for(3'h2, 1'b1);
    repeat (60) @(posedge pclk);
    chk({drive_en, flt}, 7'h04);
    nominal;
    stop;
    apb(1'b1, `MSV_A_TOL, 32'h00000063);
    start(2'h2, 1'b0);
    // a step to twice the interval, larger than the one that tripped at 50 percent, so the disabled check is really exercised
    period <= 8'h1E;
    repeat (100) @(posedge pclk);
    period <= 8'h3C;
    repeat (300) @(posedge pclk);
    chk({drive_en, flt}, 7'h40);
    end_of_test;
  end
endmodule
